// ==== hdl/secreg_cmd.sv ====
/*
 * Command decoder for the security areas (erase, program, read), the
 * quad-mode read parameters, burst wrap addressing and quad entry.
 * Assumes a host in serial clock mode 0 or 3, CS_N high for at least
 * four CLK cycles between frames, and the rest of the device owning the
 * write enable latch, the lock bits and the quad enable bit.
 */
`timescale 1ns/1ps
`default_nettype none

module secreg_cmd #(
   parameter int ERASE_TIME_US = 100
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic [3:0] IO_IN,
   output logic [3:0] IO_OUT,
   output logic [3:0] IO_OE,
   input wire logic WRITE_ENABLE_LATCH,
   input wire logic [3:1] OTP_AREA_LOCK_BITS,
   input wire logic QUAD_ENABLE_BIT,
   input wire logic FOUR_BYTE_MODE,
   input wire logic SOFT_RESET,
   input wire logic [31:0] BURST_ADDR_IN,
   output logic BUSY,
   output logic QUAD_COMMAND_MODE,
   output logic [1:0] SERIAL_WRAP_FIELD,
   output var logic [3:0] DUMMY_CLOCKS,
   output var logic [6:0] WRAP_BYTES,
   output var logic [31:0] BURST_ADDR_NEXT
);

   localparam int ERASE_CYC = ERASE_TIME_US * secreg_pkg::CLK_MHZ;

   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} state_t;

   // system side
   logic cs_s1, cs_s2, cs_s3;
   logic end_ev;
   logic four_reg;
   logic quad_reg;
   logic [1:0] dummy_f_reg;
   logic [1:0] wrap_f_reg;
   logic [1:0] swrap_reg;
   state_t state_reg;
   logic busy_reg;
   logic [23:0] tmr_reg;
   logic [1:0] area_reg;
   // link side
   logic fresh_reg;
   logic busy_l1, busy_l2;
   logic [15:0] bits_reg, bits_next;
   logic [31:0] sr_reg, sr_next;
   logic [7:0] op_reg;
   logic [31:0] addr_reg;
   logic accept_reg;
   logic got_data_reg;
   logic [7:0] nbyte_reg;
   logic [255:0] pmask_reg;
   logic [7:0] pbuf [0:255];
   logic prog_byte;
   logic [7:0] pidx;
   logic [15:0] a_end;
   logic [15:0] rd_start;
   logic [2:0] obit_reg;
   logic [7:0] roff_reg;
   logic dout_reg, oe_reg;
   logic [7:0] rd_byte;
   // evaluation at frame end
   logic [1:0] area_l;
   logic locked;
   logic idle;
   logic go_erase, go_prog, go_param, go_quad, go_swrap;
   logic [7:0] last_byte;

   secreg_mem_if mif();

   secreg_store u_store (
      .clk(CLK),
      .m(mif)
   );

   // ****************************************
   // link side, clocked by the host
   // ****************************************

   // the link clock may stop between frames, so the frame start is
   // flagged by select and consumed by the first edge
   always_ff @(posedge SCK or posedge CS_N) begin
      if (CS_N) begin
         fresh_reg <= 1'b1;
      end else begin
         fresh_reg <= 1'b0;
      end
   end

   always_ff @(posedge SCK) begin
      busy_l1 <= busy_reg;
      busy_l2 <= busy_l1;
   end

   assign a_end = four_reg ? secreg_pkg::ADDR_END4 : secreg_pkg::ADDR_END3;
   assign rd_start = a_end + secreg_pkg::DUMMY_BITS;

   always_comb begin
      bits_next = (fresh_reg ? 16'h0000 : bits_reg) + (quad_reg ? 16'h0004 : 16'h0001);
      if (quad_reg) begin
         sr_next = {sr_reg[27:0], IO_IN};
      end else begin
         sr_next = {sr_reg[30:0], IO_IN[0]};
      end
   end

   // frame fields stay put after select rises; the system side reads them
   // only then, which is what makes this crossing safe
   always_ff @(posedge SCK) begin
      sr_reg <= sr_next;
      if (!bits_next[15]) begin
         bits_reg <= bits_next;
      end
      if (bits_next == secreg_pkg::OPC_BITS) begin
         op_reg <= sr_next[7:0];
      end
      if (bits_next == a_end) begin
         addr_reg <= four_reg ? sr_next : {8'h00, sr_next[23:0]};
      end
   end

   // a program or read is taken only if not busy at its opcode
   always_ff @(posedge SCK) begin
      if (bits_next == secreg_pkg::OPC_BITS) begin
         accept_reg <= !busy_l2;
      end else if (fresh_reg) begin
         accept_reg <= 1'b0;
      end
   end

   assign prog_byte = !fresh_reg && op_reg == secreg_pkg::OP_PROG && accept_reg &&
                      bits_next > a_end && bits_next[2:0] == 3'h0;
   assign pidx = addr_reg[7:0] + nbyte_reg;

   // data bytes gathered within the 256-byte page
   always_ff @(posedge SCK) begin
      if (fresh_reg) begin
         nbyte_reg <= 8'h00;
         got_data_reg <= 1'b0;
      end else if (prog_byte) begin
         nbyte_reg <= nbyte_reg + 8'h01;
         got_data_reg <= 1'b1;
      end
   end

   always_ff @(posedge SCK) begin
      if (bits_next == secreg_pkg::OPC_BITS && sr_next[7:0] == secreg_pkg::OP_PROG &&
          !busy_l2) begin
         pmask_reg <= '0;
      end else if (prog_byte) begin
         pmask_reg[pidx] <= 1'b1;
      end
   end

   always_ff @(posedge SCK) begin
      if (prog_byte) begin
         pbuf[pidx] <= sr_next[7:0];
      end
   end

   // area decode from the captured address
   assign area_l = secreg_pkg::area_of(addr_reg, four_reg);
   assign mif.rd_area = area_l;
   assign mif.rd_idx = addr_reg[7:0] + roff_reg;
   // bytes outside all areas read blank
   assign rd_byte = (area_l == 2'h0) ? secreg_pkg::BLANK_BYTE : mif.rd_data;

   // data leaves on falling edges, MSB first
   always_ff @(negedge SCK or posedge CS_N) begin
      if (CS_N) begin
         obit_reg <= 3'h0;
         roff_reg <= 8'h00;
         dout_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (!fresh_reg && op_reg == secreg_pkg::OP_READ && accept_reg &&
                   !quad_reg && bits_reg >= rd_start) begin
         oe_reg <= 1'b1;
         dout_reg <= rd_byte[3'h7 - obit_reg];
         obit_reg <= obit_reg + 3'h1;
         // byte offset wraps inside the area
         if (obit_reg == 3'h7) begin
            roff_reg <= roff_reg + 8'h01;
         end
      end
   end

   assign IO_OUT = {2'b00, dout_reg, 1'b0};
   assign IO_OE = {2'b00, oe_reg, 1'b0};

   // ****************************************
   // system side: frame end and decisions
   // ****************************************

   // select is a pin: two flops, then the third only for the edge
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
      end else begin
         cs_s1 <= CS_N;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
      end
   end

   assign end_ev = cs_s2 && !cs_s3;

   // address width must not change under a running frame
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         four_reg <= 1'b0;
      end else if (cs_s2 && cs_s3) begin
         four_reg <= FOUR_BYTE_MODE;
      end
   end

   assign idle = state_reg == ST_IDLE;
   assign last_byte = sr_reg[7:0];
   // lock bit of the addressed area
   assign locked = (area_l != 2'h0) && OTP_AREA_LOCK_BITS[area_l];

   // erase needs latch, exact length, open area
   assign go_erase = end_ev && idle && op_reg == secreg_pkg::OP_ERASE &&
                     bits_reg == a_end && WRITE_ENABLE_LATCH &&
                     area_l != 2'h0 && !locked;
   // a program counts only with whole data bytes
   assign go_prog = end_ev && idle && op_reg == secreg_pkg::OP_PROG && accept_reg &&
                    got_data_reg && bits_reg[2:0] == 3'h0 && WRITE_ENABLE_LATCH &&
                    area_l != 2'h0 && !locked;
   // parameters only in quad command mode
   assign go_param = end_ev && quad_reg && op_reg == secreg_pkg::OP_PARAM &&
                     bits_reg == secreg_pkg::PARAM_END;
   // quad entry needs the quad enable bit
   assign go_quad = end_ev && !quad_reg && op_reg == secreg_pkg::OP_QUAD &&
                    bits_reg == secreg_pkg::OPC_BITS && QUAD_ENABLE_BIT;
   assign go_swrap = end_ev && !quad_reg && op_reg == secreg_pkg::OP_SWRAP &&
                     bits_reg == secreg_pkg::SWRAP_END;

   // ****************************************
   // settings
   // ****************************************

   always_ff @(posedge CLK) begin
      if (!RST_N || SOFT_RESET) begin
         quad_reg <= 1'b0;
         dummy_f_reg <= secreg_pkg::DUMMY_DEFAULT;
         wrap_f_reg <= secreg_pkg::WRAP_DEFAULT;
         swrap_reg <= secreg_pkg::SWRAP_DEFAULT;
      end else begin
         if (go_param) begin
            dummy_f_reg <= last_byte[secreg_pkg::DUMMY_LSB +: 2];
            wrap_f_reg <= last_byte[secreg_pkg::WRAP_LSB +: 2];
         end
         // entry resets wrap, latch left alone
         if (go_quad) begin
            quad_reg <= 1'b1;
            wrap_f_reg <= secreg_pkg::WRAP_DEFAULT;
         end
         // serial wrap field, only when wrap is on
         if (go_swrap && !last_byte[secreg_pkg::SWRAP_OFF_BIT]) begin
            swrap_reg <= last_byte[secreg_pkg::SWRAP_LSB +: 2];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         DUMMY_CLOCKS <= secreg_pkg::SERIAL_DUMMY_CLOCKS;
         WRAP_BYTES <= secreg_pkg::wrap_bytes(secreg_pkg::WRAP_DEFAULT);
         BURST_ADDR_NEXT <= 32'h00000000;
      end else if (quad_reg) begin
         DUMMY_CLOCKS <= secreg_pkg::dummy_clocks(dummy_f_reg);
         WRAP_BYTES <= secreg_pkg::wrap_bytes(wrap_f_reg);
         // next burst address stays in the window
         BURST_ADDR_NEXT <= secreg_pkg::wrap_next(BURST_ADDR_IN, wrap_f_reg);
      end else begin
         DUMMY_CLOCKS <= secreg_pkg::SERIAL_DUMMY_CLOCKS;
         WRAP_BYTES <= secreg_pkg::wrap_bytes(swrap_reg);
         BURST_ADDR_NEXT <= secreg_pkg::wrap_next(BURST_ADDR_IN, swrap_reg);
      end
   end

   assign QUAD_COMMAND_MODE = quad_reg;
   assign SERIAL_WRAP_FIELD = swrap_reg;
   assign BUSY = busy_reg;

   // ****************************************
   // self-timed erase and program
   // ****************************************

   // busy only for an accepted operation
   always_ff @(posedge CLK) begin
      if (!RST_N || SOFT_RESET) begin
         state_reg <= ST_IDLE;
         busy_reg <= 1'b0;
         tmr_reg <= 24'h000000;
         area_reg <= 2'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               tmr_reg <= 24'h000000;
               area_reg <= area_l;
               if (go_erase) begin
                  state_reg <= ST_ERASE;
                  busy_reg <= 1'b1;
               end else if (go_prog) begin
                  state_reg <= ST_PROG;
                  busy_reg <= 1'b1;
               end
            end
            ST_ERASE: begin
               tmr_reg <= tmr_reg + 24'h000001;
               if (tmr_reg == 24'(ERASE_CYC - 1)) begin
                  state_reg <= ST_IDLE;
                  busy_reg <= 1'b0;
               end
            end
            ST_PROG: begin
               tmr_reg <= tmr_reg + 24'h000001;
               if (tmr_reg == 24'(secreg_pkg::AREA_BYTES - 1)) begin
                  state_reg <= ST_IDLE;
                  busy_reg <= 1'b0;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               busy_reg <= 1'b0;
            end
         endcase
      end
   end

   // one byte per cycle; erase fills the area first
   always_comb begin
      mif.wr_erase = state_reg == ST_ERASE;
      mif.wr_area = area_reg;
      mif.wr_idx = tmr_reg[7:0];
      mif.wr_data = pbuf[tmr_reg[7:0]];
      mif.wr_en = 1'b0;
      if (state_reg == ST_ERASE) begin
         mif.wr_en = tmr_reg < 24'(secreg_pkg::AREA_BYTES);
      end else if (state_reg == ST_PROG) begin
         mif.wr_en = pmask_reg[tmr_reg[7:0]];
      end
   end

   // ****************************************
   // checks
   // ****************************************

   a_erase_busy: assert property (p_erase_busy) else $error("erase did not hold busy");
   property p_erase_busy;
      @(posedge CLK) disable iff (!RST_N || SOFT_RESET) go_erase |=> busy_reg [*8];
   endproperty

   a_no_wel: assert property (p_no_wel) else $error("erase ran without latch");
   property p_no_wel;
      @(posedge CLK) disable iff (!RST_N)
         end_ev && idle && op_reg == secreg_pkg::OP_ERASE && !WRITE_ENABLE_LATCH
         |=> !busy_reg ##1 !busy_reg;
   endproperty

   a_locked: assert property (p_locked) else $error("locked area went busy");
   property p_locked;
      @(posedge CLK) disable iff (!RST_N) end_ev && idle && locked |=> !busy_reg;
   endproperty

   a_erase_len: assert property (p_erase_len) else $error("misaligned erase ran");
   property p_erase_len;
      @(posedge CLK) disable iff (!RST_N)
         end_ev && idle && op_reg == secreg_pkg::OP_ERASE && bits_reg != a_end
         |=> !busy_reg;
   endproperty

   a_prog_busy: assert property (p_prog_busy) else $error("program busy too short");
   property p_prog_busy;
      @(posedge CLK) disable iff (!RST_N || SOFT_RESET) go_prog |=> busy_reg [*8];
   endproperty

   a_param_serial: assert property (p_param_serial) else $error("C0 taken in serial");
   property p_param_serial;
      @(posedge CLK) disable iff (!RST_N || SOFT_RESET)
         end_ev && !quad_reg && op_reg == secreg_pkg::OP_PARAM |=> $stable(dummy_f_reg);
   endproperty

   a_param_quad: assert property (p_param_quad) else $error("dummy field not stored");
   property p_param_quad;
      @(posedge CLK) disable iff (!RST_N || SOFT_RESET)
         go_param ##1 !SOFT_RESET |-> dummy_f_reg == $past(last_byte[5:4]) &&
         DUMMY_CLOCKS == $past(DUMMY_CLOCKS) ##1 DUMMY_CLOCKS == {1'b0, dummy_f_reg, 1'b0} + 4'h2;
   endproperty

   a_quad_qe: assert property (p_quad_qe) else $error("quad entered without enable");
   property p_quad_qe;
      @(posedge CLK) disable iff (!RST_N)
         end_ev && !quad_reg && !QUAD_ENABLE_BIT |=> !quad_reg;
   endproperty

   a_quad_wrap: assert property (p_quad_wrap) else $error("wrap kept on quad entry");
   property p_quad_wrap;
      @(posedge CLK) disable iff (!RST_N) $rose(quad_reg) |-> wrap_f_reg == 2'h0;
   endproperty

   a_soft_reset: assert property (p_soft_reset) else $error("reset left settings");
   property p_soft_reset;
      @(posedge CLK) disable iff (!RST_N)
         SOFT_RESET |=> !quad_reg && !busy_reg && dummy_f_reg == 2'h0 && wrap_f_reg == 2'h0
         ##1 DUMMY_CLOCKS == 4'h8;
   endproperty

endmodule

`default_nettype wire

// ==== hdl/secreg_pkg.sv ====
/*
 * Constants, field layouts and helper functions of the security-area,
 * read-parameter and quad-entry command decoder of the serial flash.
 * Assumes one system clock of 50 MHz and a host-driven serial clock.
 */
// Behaviour
// - three 256-byte OTP areas, separately erased
// - erase 44h needs write enable latch set
// - area picked by address bits 15:12
// - erase runs only if frame ends on byte
// - busy held high for whole self-timed erase
// - lock bit set blocks erase and program
// - four-byte mode uses 32-bit address
// - program 42h writes 1-256 bytes, needs latch
// - read 48h: address, eight dummies, MSB first
// - read address wraps FFh to 00h
// - read ignored while busy
// - undefined area reads return FFh
// - read parameters accepted in quad mode only
// - dummy field picks 2, 4, 6, 8 clocks
// - wrap field picks 8, 16, 32, 64 bytes
// - reset defaults: 8-byte wrap, 2 dummies
// - serial mode wrap from serial wrap field
// - burst wrap stays inside aligned window
// - 38h enters quad mode only with enable bit
// - quad entry keeps latch, resets wrap length
// - reset clears read parameters and wrap field

package secreg_pkg;

   // ****************************************
   // opcodes and frame lengths in bits
   // ****************************************
   localparam logic [7:0] OP_ERASE = 8'h44;
   localparam logic [7:0] OP_PROG = 8'h42;
   localparam logic [7:0] OP_READ = 8'h48;
   localparam logic [7:0] OP_PARAM = 8'hC0;
   localparam logic [7:0] OP_QUAD = 8'h38;
   localparam logic [7:0] OP_SWRAP = 8'h77;
   localparam logic [15:0] OPC_BITS = 16'h0008;
   localparam logic [15:0] ADDR_END3 = 16'h0020;
   localparam logic [15:0] ADDR_END4 = 16'h0028;
   localparam logic [15:0] DUMMY_BITS = 16'h0008;
   localparam logic [15:0] PARAM_END = 16'h0010;
   localparam logic [15:0] SWRAP_END = 16'h0028;

   // ****************************************
   // timing, sizes, field positions, defaults
   // ****************************************
   localparam int CLK_MHZ = 50;
   localparam int AREA_BYTES = 256;
   localparam int DUMMY_LSB = 4;
   localparam int WRAP_LSB = 0;
   localparam int SWRAP_LSB = 4;
   localparam int SWRAP_OFF_BIT = 6;
   localparam logic [1:0] DUMMY_DEFAULT = 2'h0;
   localparam logic [1:0] WRAP_DEFAULT = 2'h0;
   localparam logic [1:0] SWRAP_DEFAULT = 2'h0;
   localparam logic [3:0] SERIAL_DUMMY_CLOCKS = 4'h8;
   localparam logic [7:0] BLANK_BYTE = 8'hFF;

   // area 1..3, or 0 when the address is outside every area
   function automatic logic [1:0] area_of(input logic [31:0] a, input logic four);
      logic hi_zero;
      logic [1:0] r;
      hi_zero = four ? (a[31:16] == 16'h0000) : (a[23:16] == 8'h00);
      r = 2'h0;
      if (hi_zero && a[11:8] == 4'h0 && a[15:14] == 2'h0) begin
         r = a[13:12];
      end
      return r;
   endfunction

   function automatic logic [3:0] dummy_clocks(input logic [1:0] f);
      return {1'b0, f, 1'b0} + 4'h2;
   endfunction

   function automatic logic [6:0] wrap_bytes(input logic [1:0] f);
      return 7'h08 << f;
   endfunction

   function automatic logic [31:0] wrap_next(input logic [31:0] a, input logic [1:0] f);
      logic [31:0] m;
      m = (32'h00000008 << f) - 32'h00000001;
      return (a & ~m) | ((a + 32'h00000001) & m);
   endfunction

endpackage

// ==== hdl/secreg_mem_if.sv ====
/*
 * Port bundle between the command decoder and the security-area store.
 * Writes belong to the system clock; the read port is combinational.
 */
`timescale 1ns/1ps
`default_nettype none

interface secreg_mem_if;
   logic wr_en;
   logic wr_erase;
   logic [1:0] wr_area;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;
   logic [1:0] rd_area;
   logic [7:0] rd_idx;
   logic [7:0] rd_data;

   modport store(input wr_en, wr_erase, wr_area, wr_idx, wr_data, rd_area, rd_idx,
                 output rd_data);
   modport user(output wr_en, wr_erase, wr_area, wr_idx, wr_data, rd_area, rd_idx,
                input rd_data);
endinterface

`default_nettype wire

// ==== hdl/secreg_store.sv ====
/*
 * Three one-time-programmable security areas of 256 bytes each.
 * Assumes writes only while the decoder is busy, so the link-side read
 * never sees a cell change under it.
 */
`timescale 1ns/1ps
`default_nettype none

module secreg_store (
   input wire logic clk,
   secreg_mem_if.store m
);

   logic [7:0] cells [1:3][0:255];

   // erase sets a byte, program clears bits only
   always_ff @(posedge clk) begin
      if (m.wr_en && m.wr_area != 2'h0) begin
         if (m.wr_erase) begin
            cells[m.wr_area][m.wr_idx] <= secreg_pkg::BLANK_BYTE;
         end else begin
            cells[m.wr_area][m.wr_idx] <= cells[m.wr_area][m.wr_idx] & m.wr_data;
         end
      end
   end

   always_comb begin
      m.rd_data = secreg_pkg::BLANK_BYTE;
      if (m.rd_area != 2'h0) begin
         m.rd_data = cells[m.rd_area][m.rd_idx];
      end
   end

endmodule

`default_nettype wire

// ==== verification/host_model.sv ====
/*
 * Host flash controller model: drives select, serial clock and data lines.
 * Assumes the bench runs one frame at a time and waits for it to finish.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model (
   output logic SCK,
   output logic CS_N,
   output logic [3:0] IO_IN,
   input wire logic [3:0] IO_OUT,
   input wire logic [3:0] IO_OE
);
   initial begin
      SCK = 1'b0;
      CS_N = 1'b1;
      IO_IN = 4'hA;
   end

   // ****************************************
   // one frame: n bits out, then r bits back
   // ****************************************
   // opcode, address, data in one select
   task automatic xfer(input logic [63:0] d, input int n, input logic q, input int r,
                       output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      #33 CS_N = 1'b0;
      for (i = 0; i < n; i += (q ? 4 : 1)) begin
         if (q) begin
            IO_IN = d[63-i -: 4];
         end else begin
            IO_IN = {~IO_IN[3:1], d[63-i]};
         end
         #80 SCK = 1'b1;
         #80 SCK = 1'b0;
      end
      // sample just before each rising edge
      for (i = 0; i < r; i++) begin
         #80 rd = {rd[14:0], IO_OUT[1]};
         SCK = 1'b1;
         #80 SCK = 1'b0;
      end
      // select rises on a byte boundary
      #80 CS_N = 1'b1;
      // released lines show no stale value
      IO_IN = ~IO_IN;
      #200;
   endtask
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for the security-area and read-parameter decoder.
 * Assumes the host model owns the link and the bench owns the status inputs.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic clk, rst_n, sck, cs_n, write_enable_latch, qe, four, sreset, busy, quad;
   logic [3:0] io_in, io_out, io_oe, dummies;
   logic [3:1] locks;
   logic [31:0] baddr, bnext;
   logic [1:0] swrap;
   logic [6:0] wrapb;
   logic [15:0] rd;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   logic oe_seen = 1'b0;

   // any drive of the read data line during a frame
   always @(posedge io_oe[1]) oe_seen = 1'b1;

   secreg_cmd #(.ERASE_TIME_US(6)) DUT (
      .CLK(clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .IO_IN(io_in),
      .IO_OUT(io_out), .IO_OE(io_oe), .WRITE_ENABLE_LATCH(write_enable_latch),
      .OTP_AREA_LOCK_BITS(locks), .QUAD_ENABLE_BIT(qe), .FOUR_BYTE_MODE(four),
      .SOFT_RESET(sreset), .BURST_ADDR_IN(baddr), .BUSY(busy), .QUAD_COMMAND_MODE(quad),
      .SERIAL_WRAP_FIELD(swrap), .DUMMY_CLOCKS(dummies), .WRAP_BYTES(wrapb),
      .BURST_ADDR_NEXT(bnext)
   );
   host_model host (.SCK(sck), .CS_N(cs_n), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe));

   // ****************************************
   // clock, timeout, shared tasks
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic drive(input logic w, input logic q, input logic [3:1] l);
      @(posedge clk);
      #1 write_enable_latch = w;
      qe = q;
      locks = l;
   endtask

   // sampled on falling edges, so the count is exact
   task automatic busy_len(output int n);
      n = 0;
      repeat (600) if (busy !== 1'b1) @(negedge clk);
      while (busy === 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic er(input logic [63:0] d, input int n, input int exp);
      int len;
      logic [15:0] x;
      fork
         host.xfer(d, n, 1'b0, 0, x);
         busy_len(len);
      join
      chk(32'(len), 32'(exp));
   endtask

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_defaults();
      chk({busy, quad, swrap, dummies, wrapb}, {2'h0, 2'h0, 4'h8, 7'h08});
      chk(bnext, 32'h00000001);
      $display("test defaults done");
   endtask

   task automatic t_erase();
      int a;
      drive(1'b1, 1'b0, 3'h1);
      er({8'h44, 24'h001000, 32'h0}, 32, 0);
      drive(1'b0, 1'b0, 3'h0);
      er({8'h44, 24'h001000, 32'h0}, 32, 0);
      drive(1'b1, 1'b0, 3'h0);
      er({8'h44, 24'h001000, 32'h0}, 40, 0);
      for (a = 1; a < 4; a++) begin
         er({8'h44, 8'h00, 4'(a), 12'h000, 32'h0}, 32, 300);
      end
      $display("test erase done");
   endtask

   task automatic t_prog_read();
      int len;
      // a read issued while the program still runs must stay silent
      fork
         busy_len(len);
         begin
            host.xfer({8'h42, 24'h001000, 8'hA5, 24'h0}, 40, 1'b0, 0, rd);
            oe_seen = 1'b0;
            host.xfer({8'h48, 24'h0010FF, 32'h0}, 40, 1'b0, 16, rd);
         end
      join
      chk(32'(len), 32'h00000100);
      chk({15'h0, oe_seen, rd}, 32'h00000000);
      oe_seen = 1'b0;
      host.xfer({8'h48, 24'h0010FF, 32'h0}, 40, 1'b0, 16, rd);
      chk({15'h0, oe_seen, rd}, 32'h0001FFA5);
      host.xfer({8'h48, 24'h001100, 32'h0}, 40, 1'b0, 16, rd);
      chk({16'h0000, rd}, 32'h0000FFFF);
      @(posedge clk);
      #1 four = 1'b1;
      host.xfer({8'h48, 32'h000010FF, 24'h0}, 48, 1'b0, 16, rd);
      chk({16'h0000, rd}, 32'h0000FFA5);
      @(posedge clk);
      #1 four = 1'b0;
      $display("test program read done");
   endtask

   task automatic t_modes();
      int f;
      host.xfer({8'hC0, 8'h33, 48'h0}, 16, 1'b0, 0, rd);
      chk({28'h0, dummies}, 32'h00000008);
      host.xfer({8'h77, 24'h0, 8'h20, 24'h0}, 40, 1'b0, 0, rd);
      chk({swrap, wrapb}, {2'h2, 7'h20});
      drive(1'b1, 1'b0, 3'h0);
      host.xfer({8'h38, 56'h0}, 8, 1'b0, 0, rd);
      chk({31'h0, quad}, 32'h00000000);
      drive(1'b1, 1'b1, 3'h0);
      host.xfer({8'h38, 56'h0}, 8, 1'b0, 0, rd);
      chk({quad, wrapb}, {1'b1, 7'h08});
      chk({28'h0, dummies}, 32'h00000002);
      for (f = 0; f < 4; f++) begin
         host.xfer({8'hC0, 2'h0, 2'(f), 2'h0, 2'(f), 48'h0}, 16, 1'b1, 0, rd);
         chk({dummies, wrapb}, {4'(2 + 2 * f), 7'(8 << f)});
      end
      @(posedge clk);
      #1 baddr = 32'h1234567F;
      repeat (3) @(posedge clk);
      chk(bnext, 32'h12345640);
      #1 sreset = 1'b1;
      @(posedge clk);
      #1 sreset = 1'b0;
      repeat (2) @(negedge clk);
      chk({quad, swrap, dummies, wrapb}, {1'b0, 2'h0, 4'h8, 7'h08});
      $display("test modes done");
   endtask

   initial begin
      rst_n = 1'b0;
      write_enable_latch = 1'b0;
      qe = 1'b0;
      locks = 3'h0;
      four = 1'b0;
      sreset = 1'b0;
      baddr = 32'h00000000;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge clk);
      t_defaults();
      t_erase();
      t_prog_read();
      t_modes();
      finish_test();
   end
endmodule

`default_nettype wire
